// file: verilog/adc_status_register.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_cfg.svh"
module adc_status_register (
  input  wire logic                         mclk_i,
  input  wire logic                         reset_i,
  input  wire logic                         sclk_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         din_i,
  output logic                              dout_o,
  output logic                              dout_oe_n_o,
  input  wire logic                         result_write_i,
  input  wire adc_status_pkg::result_word_t result_data_i,
  input  wire adc_status_pkg::channel_t     result_channel_i,
  input  wire logic                         pre_update_i,
  input  wire logic                         power_down_entry_i,
  input  wire logic                         idle_entry_i,
  input  wire logic                         sync_n_i,
  input  wire logic                         cal_done_i,
  input  wire logic                         cal_ref_invalid_i,
  input  wire logic                         system_cal_i,
  input  wire logic                         cal_input_out_of_range_i,
  input  wire logic                         reference_below_i,
  input  wire logic                         reference_detect_enable_i,
  input  wire logic                         parity_check_enable_i,
  input  wire logic                         append_status_to_data_i,
  output adc_status_pkg::status_byte_t      converter_status_o,
  output adc_status_pkg::result_word_t      stored_result_o,
  output logic                              missing_reference_flag_o
);
  import adc_status_pkg::*;

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------

  // Every flag takes its reset level from the register's reset byte, and
  // each synchroniser stage starts at its pin's idle level, so that no
  // false event follows the release of reset.
  localparam status_byte_t status_reset_c  = `STATUS_RESET;
  localparam logic [3:0]   sync_reset_c    = `SYNC_RESET;
  localparam channel_t     channel_reset_c = status_reset_c[`TAG_MSB:`TAG_LSB];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  status_link_if link ();

  logic [3:0]   sync_raw;
  logic [3:0]   sync1_r;
  logic [3:0]   sync2_r;
  logic         tgl_seen_r;
  logic         read_evt;
  logic         sync_low;
  logic         ref_low;
  logic         frame_idle;

  logic         ready_flag_r;
  logic         error_flag_r;
  logic         missing_reference_flag_r;
  logic         parity_flag_r;
  channel_t     result_channel_tag_r;
  result_word_t stored_result_r;
  result_word_t stored_result_nxt;
  result_word_t forced_result;
  logic         result_clamped;
  logic         cal_fault;
  status_byte_t status_word;

  status_byte_t shadow_status_r;
  result_word_t shadow_data_r;
  logic         shadow_append_r;

  // ----------------------------------------------------------------
  // Serial link front end on the link clock
  // ----------------------------------------------------------------

  // Command decoding and bit shifting run on the host's serial clock.
  // The port sees only the frozen shadow words and returns a read toggle.
  serial_status_port u_port (
    .sclk_i  (sclk_i),
    .cs_n_i  (cs_n_i),
    .reset_i (reset_i),
    .din_i   (din_i),
    .link    (link.port)
  );

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  // Pins and the link-domain read toggle gathered for two-stage capture.
  // Chip select crosses too, so the shadow copy knows when a frame runs.
  always_comb
  begin
    sync_raw              = 4'h0;
    sync_raw[`SYNC_IDX_N] = sync_n_i;
    sync_raw[`REF_IDX]    = reference_below_i;
    sync_raw[`CS_IDX]     = cs_n_i;
    sync_raw[`TGL_IDX]    = link.data_read_tgl;
  end

  // Two flip-flops per input; only the second stage is looked at.
  // Reset loads each stage with its pin's idle level, so the first
  // change seen after reset is a real one.
  for (genvar g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        sync1_r[g] <= sync_reset_c[g];
        sync2_r[g] <= sync_reset_c[g];
      end
      else
      begin
        sync1_r[g] <= sync_raw[g];
        sync2_r[g] <= sync1_r[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read event and pin levels in the core clock domain
  // ----------------------------------------------------------------

  // Edge detector on the synchronised read toggle. The toggle crosses as a
  // single bit, so one data read can never be seen twice or lost.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tgl_seen_r <= 1'b0;
    else
      tgl_seen_r <= sync2_r[`TGL_IDX];
  end

  // Each consumer reads only the second synchroniser stage.
  assign read_evt   = sync2_r[`TGL_IDX] ^ tgl_seen_r;
  assign sync_low   = ~sync2_r[`SYNC_IDX_N];
  assign ref_low    = sync2_r[`REF_IDX];
  assign frame_idle = sync2_r[`CS_IDX];

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------

  // A missing reference forces the stored result to all ones.
  // The flag is the registered one, so the word and the flag agree.
  always_comb
  begin
    forced_result = result_data_i;
    if (missing_reference_flag_r)
      forced_result = `RESULT_ONES;
  end

  // Next content of the data register, used by the parity tracker too.
  always_comb
  begin
    stored_result_nxt = stored_result_r;
    if (result_write_i)
      stored_result_nxt = forced_result;
  end

  // Clamping shows as an all-zero or all-one stored word.
  // Overrange, underrange and a lost reference all end up this way.
  assign result_clamped = (forced_result == `RESULT_ZERO) ||
                          (forced_result == `RESULT_ONES);

  // Calibration faults: a bad reference, or bad inputs in system calibration.
  // These levels are only looked at with the calibration-done pulse.
  assign cal_fault = cal_ref_invalid_i ||
                     (system_cal_i && cal_input_out_of_range_i);

  // Data register copy, loaded only when a conversion result is written.
  // It is the word a data read shifts out and the parity source.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      stored_result_r <= `RESULT_ZERO;
    else
      stored_result_r <= stored_result_nxt;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------

  // Ready flag: forced set by sync low or mode entry, cleared by a new
  // result, set by a completed data read or the pre-update warning.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      ready_flag_r <= status_reset_c[`RDY_BIT];
    else if (sync_low || power_down_entry_i || idle_entry_i)
      ready_flag_r <= 1'b1;
    else if (result_write_i)
      ready_flag_r <= 1'b0;
    else if (read_evt || pre_update_i)
      ready_flag_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Error, reference and parity flags
  // ----------------------------------------------------------------

  // Error flag is rewritten with every stored result, in the cycle of the write,
  // even when a forced set keeps the ready flag high, and at the end of each calibration without a result write in that cycle.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      error_flag_r <= status_reset_c[`ERR_BIT];
    else if (result_write_i)
      error_flag_r <= result_clamped;
    else if (cal_done_i)
      error_flag_r <= cal_fault;
  end

  // Missing-reference flag follows the comparator while detection is enabled.
  // With detection off it stays clear whatever the comparator says.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      missing_reference_flag_r <= status_reset_c[`MISSING_REF_BIT];
    else
      missing_reference_flag_r <= reference_detect_enable_i && ref_low;
  end

  // Parity tracks the data register content while checking is enabled.
  // It is taken from the next content, so it lines up with the stored word.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      parity_flag_r <= status_reset_c[`PARITY_BIT];
    else
      parity_flag_r <= parity_check_enable_i && (^stored_result_nxt);
  end

  // ----------------------------------------------------------------
  // Channel tag and register image
  // ----------------------------------------------------------------

  // Channel tag is loaded with the result, never from the live channel.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      result_channel_tag_r <= channel_reset_c;
    else if (result_write_i)
      result_channel_tag_r <= result_channel_i;
  end

  // Register image; bit order matches the serial stream, ready first.
  // It is what the shadow copy and the observation port both carry.
  assign status_word = {ready_flag_r,
                        error_flag_r,
                        missing_reference_flag_r,
                        parity_flag_r,
                        result_channel_tag_r};

  // ----------------------------------------------------------------
  // Shadow copy seen by the link domain
  // ----------------------------------------------------------------

  // The copy is refreshed only between frames and held while chip select
  // is low, so the link clock always loads a settled word. Only a completed
  // data read feeds back into the flags, by setting the ready flag.
  // Frames must be at least three core cycles apart for the copy to refresh.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      shadow_status_r <= `STATUS_RESET;
      shadow_data_r   <= `RESULT_ZERO;
      shadow_append_r <= 1'b0;
    end
    else if (frame_idle)
    begin
      shadow_status_r <= status_word;
      shadow_data_r   <= stored_result_r;
      shadow_append_r <= append_status_to_data_i;
    end
  end

  // Frozen words handed to the link-clock shifter.
  assign link.shadow_status = shadow_status_r;
  assign link.shadow_data   = shadow_data_r;
  assign link.append        = shadow_append_r;

  // ----------------------------------------------------------------
  // Serial output pin and its enable
  // ----------------------------------------------------------------

  // Between transfers the serial output shows the ready flag, low while
  // fresh data wait, so a host may poll the pin instead of the register.
  assign dout_o      = link.shifting ? link.shift_bit : ready_flag_r;
  assign dout_oe_n_o = cs_n_i;

  // ----------------------------------------------------------------
  // Observation outputs
  // ----------------------------------------------------------------

  // Copies of the register image, the stored word and the reference flag.
  assign converter_status_o       = status_word;
  assign stored_result_o          = stored_result_r;
  assign missing_reference_flag_o = missing_reference_flag_r;
endmodule
`default_nettype wire

// file: inc/adc_status_cfg.svh
`ifndef ADC_STATUS_CFG_SVH
`define ADC_STATUS_CFG_SVH
`define STATUS_RESET   8'h80
`define RDY_BIT        7
`define ERR_BIT        6
`define MISSING_REF_BIT 5
`define PARITY_BIT     4
`define TAG_MSB        3
`define TAG_LSB        0
`define SEL_STATUS     3'h0
`define SEL_DATA       3'h3
`define CMD_LAST       3'h6
`define CMD_RW_BIT     6
`define CMD_SEL_MSB    5
`define CMD_SEL_LSB    3
`define STATUS_BITS    6'h08
`define DATA_BITS      6'h18
`define DATA_STA_BITS  6'h20
`define SYNC_RESET     4'h5
`define SYNC_IDX_N     0
`define REF_IDX        1
`define CS_IDX         2
`define TGL_IDX        3
`define RESULT_ZERO    24'h000000
`define RESULT_ONES    24'hffffff
`endif

// file: inc/adc_status_pkg.sv
package adc_status_pkg;
  typedef enum logic [1:0] {ser_wait_wen, ser_cmd, ser_shift} ser_state_t;
  typedef logic [7:0]  status_byte_t;
  typedef logic [23:0] result_word_t;
  typedef logic [3:0]  channel_t;
endpackage

// file: inc/status_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface status_link_if;
  import adc_status_pkg::*;
  status_byte_t shadow_status;
  result_word_t shadow_data;
  logic         append;
  logic         data_read_tgl;
  logic         shifting;
  logic         shift_bit;
  modport core (output shadow_status, output shadow_data, output append,
                input data_read_tgl, input shifting, input shift_bit);
  modport port (input shadow_status, input shadow_data, input append,
                output data_read_tgl, output shifting, output shift_bit);
endinterface
`default_nettype wire

// file: verilog/serial_status_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_cfg.svh"
module serial_status_port (
  input  wire logic   sclk_i,
  input  wire logic   cs_n_i,
  input  wire logic   reset_i,
  input  wire logic   din_i,
  status_link_if.port link
);
  import adc_status_pkg::*;

  ser_state_t  state_r;
  logic [6:0]  cmd_r;
  logic [2:0]  cmd_cnt_r;
  logic [31:0] shift_r;
  logic [5:0]  bit_cnt_r;
  logic        is_data_r;
  logic        read_tgl_r;
  logic [6:0]  cmd_word;
  logic        rd_status;
  logic        rd_data;
  logic        cmd_last;

  // Decode of the complete command byte on its last bit.
  assign cmd_word  = {cmd_r[5:0], din_i};
  assign cmd_last  = (state_r == ser_cmd) && (cmd_cnt_r == `CMD_LAST);
  assign rd_status = cmd_word[`CMD_RW_BIT] &&
                     (cmd_word[`CMD_SEL_MSB:`CMD_SEL_LSB] == `SEL_STATUS);
  assign rd_data   = cmd_word[`CMD_RW_BIT] &&
                     (cmd_word[`CMD_SEL_MSB:`CMD_SEL_LSB] == `SEL_DATA);

  // Frame sequencer; a high chip select ends any frame at once.
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      state_r <= ser_wait_wen;
    else
      case (state_r)
        ser_wait_wen:
          if (!din_i)
            state_r <= ser_cmd;
        ser_cmd:
          if (cmd_last)
            state_r <= (rd_status || rd_data) ? ser_shift : ser_wait_wen;
        ser_shift:
          if (bit_cnt_r == 6'h01)
            state_r <= ser_wait_wen;
        default:
          state_r <= ser_wait_wen;
      endcase
  end

  // Collects the seven command bits after the write-enable zero.
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      cmd_r     <= 7'h00;
      cmd_cnt_r <= 3'h0;
    end
    else if (state_r == ser_cmd)
    begin
      cmd_r     <= cmd_word;
      cmd_cnt_r <= cmd_cnt_r + 3'h1;
    end
    else
      cmd_cnt_r <= 3'h0;
  end

  // Output shifter, loaded from the frozen shadow copy, most significant bit first.
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      shift_r   <= 32'h00000000;
      bit_cnt_r <= 6'h00;
      is_data_r <= 1'b0;
    end
    else if (cmd_last && rd_status)
    begin
      shift_r   <= {link.shadow_status, 24'h000000};
      bit_cnt_r <= `STATUS_BITS;
      is_data_r <= 1'b0;
    end
    else if (cmd_last && rd_data)
    begin
      shift_r   <= {link.shadow_data, link.shadow_status};
      bit_cnt_r <= link.append ? `DATA_STA_BITS : `DATA_BITS;
      is_data_r <= 1'b1;
    end
    else if (state_r == ser_shift)
    begin
      shift_r   <= {shift_r[30:0], 1'b0};
      bit_cnt_r <= bit_cnt_r - 6'h01;
    end
  end

  // Completed data reads are reported by a toggle that survives the frame end.
  always_ff @(posedge sclk_i or posedge reset_i)
  begin
    if (reset_i)
      read_tgl_r <= 1'b0;
    else if ((state_r == ser_shift) && (bit_cnt_r == 6'h01) && is_data_r)
      read_tgl_r <= ~read_tgl_r;
  end

  assign link.data_read_tgl = read_tgl_r;
  assign link.shifting      = (state_r == ser_shift);
  assign link.shift_bit     = shift_r[31];
endmodule
`default_nettype wire

// file: verification/adc_status_register_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_status_register_assertions (
  input wire logic                         mclk_i,
  input wire logic                         reset_i,
  input wire logic                         sync_n_i,
  input wire logic                         result_write_i,
  input wire logic                         power_down_entry_i,
  input wire logic                         idle_entry_i,
  input wire logic                         cal_done_i,
  input wire logic                         cal_ref_invalid_i,
  input wire logic                         reference_detect_enable_i,
  input wire logic                         parity_check_enable_i,
  input wire logic                         missing_reference_flag_o,
  input wire adc_status_pkg::channel_t     result_channel_i,
  input wire adc_status_pkg::result_word_t result_data_i,
  input wire adc_status_pkg::status_byte_t converter_status_o,
  input wire adc_status_pkg::result_word_t stored_result_o
);
  import adc_status_pkg::*;
  // ----------------------------------------
  // Clocking and event sequences
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // The sync pin has held one level long enough to pass the synchroniser.
  sequence sync_high_s;
    sync_n_i [*4];
  endsequence
  sequence sync_low_s;
    !sync_n_i [*4];
  endsequence
  // A result write with no mode-entry or calibration event beside it.
  sequence plain_write_s;
    result_write_i && !power_down_entry_i && !idle_entry_i && !cal_done_i;
  endsequence
  // ----------------------------------------
  // Flag and stored result assertions
  // ----------------------------------------
  reset_val_a: assert property (disable iff (1'b0)
    reset_i |=> converter_status_o == 8'h80) else $error("status not at reset value");
  ready_clear_a: assert property (sync_high_s ##0 plain_write_s
    |=> !converter_status_o[7]) else $error("ready not cleared by result write");
  err_write_a: assert property (plain_write_s
    |=> converter_status_o[6] == (&stored_result_o || ~|stored_result_o))
    else $error("error flag does not match stored word");
  chan_tag_a: assert property (result_write_i
    |=> converter_status_o[3:0] == $past(result_channel_i)) else $error("channel tag wrong");
  force_ones_a: assert property (result_write_i && missing_reference_flag_o
    |=> stored_result_o == 24'hffffff) else $error("result not forced to ones");
  store_word_a: assert property (result_write_i && !missing_reference_flag_o
    |=> stored_result_o == $past(result_data_i)) else $error("result word not stored");
  parity_a: assert property (result_write_i && parity_check_enable_i
    |=> converter_status_o[4] == ^stored_result_o) else $error("parity flag wrong");
  missing_reference_flag_off_a: assert property (!reference_detect_enable_i [*2]
    |-> !missing_reference_flag_o) else $error("reference flag set while disabled");
  sync_ready_a: assert property (sync_low_s |-> converter_status_o[7])
    else $error("ready not held while sync low");
  mode_ready_a: assert property (power_down_entry_i || idle_entry_i
    |=> converter_status_o[7]) else $error("ready not set on mode entry");
  cal_err_a: assert property (cal_done_i && cal_ref_invalid_i && !result_write_i
    |=> converter_status_o[6]) else $error("error not set on bad calibration");
endmodule
bind adc_status_register adc_status_register_assertions chk (
  .mclk_i, .reset_i, .sync_n_i, .result_write_i, .power_down_entry_i, .idle_entry_i,
  .cal_done_i, .cal_ref_invalid_i, .reference_detect_enable_i, .parity_check_enable_i,
  .missing_reference_flag_o, .result_channel_i, .result_data_i, .converter_status_o,
  .stored_result_o
);
`default_nettype wire

// file: verification/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic din_o,
  input  wire logic dout_i
);
  // Link clock stands low and data idles high outside frames.
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b1;
  end
  // One frame: lead ones, a command byte, then n answer bits taken on falling edges.
  task automatic xfer(input logic [7:0] cmd, input int lead, input int n,
                      output logic [31:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #40;
    for (int k = 0; k < lead + 8 + n; k++)
    begin
      din_o = (k < lead || k >= lead + 8) ? 1'b1 : cmd[7 - (k - lead)];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
      if (k >= lead + 7 && k < lead + 7 + n)
        rx = {rx[30:0], dout_i};
    end
    #16 cs_n_o = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// file: verification/adc_status_register_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_status_register_tb;
  import adc_status_pkg::*;
  logic         mclk_i = 1'b0, reset_i = 1'b1, sync_n_i = 1'b1, result_write_i = 1'b0;
  logic         pre_update_i = 1'b0, power_down_entry_i = 1'b0, idle_entry_i = 1'b0;
  logic         cal_done_i = 1'b0, cal_ref_invalid_i = 1'b0, system_cal_i = 1'b0;
  logic         cal_input_out_of_range_i = 1'b0, reference_below_i = 1'b0;
  logic         reference_detect_enable_i = 1'b0, parity_check_enable_i = 1'b0;
  logic         append_status_to_data_i = 1'b0, sclk_i, cs_n_i, din_i;
  logic         dout_o, dout_oe_n_o, missing_reference_flag_o;
  result_word_t result_data_i = '0, stored_result_o;
  channel_t     result_channel_i = '0;
  status_byte_t converter_status_o;
  int           error_cnt = 0, samples_checked = 0, cycles = 0;
  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  adc_status_register DUT (.mclk_i, .reset_i, .sclk_i, .cs_n_i, .din_i, .dout_o, .dout_oe_n_o,
    .result_write_i, .result_data_i, .result_channel_i, .pre_update_i, .power_down_entry_i,
    .idle_entry_i, .sync_n_i, .cal_done_i, .cal_ref_invalid_i, .system_cal_i,
    .cal_input_out_of_range_i, .reference_below_i, .reference_detect_enable_i,
    .parity_check_enable_i, .append_status_to_data_i, .converter_status_o, .stored_result_o,
    .missing_reference_flag_o);
  host_link_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));
  always #12.5 mclk_i = ~mclk_i;
  // A hung run is cut short and counted as a mismatch.
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle pulse on the falling edge, then time for the flags to settle.
  task automatic pulse(ref logic s);
    @(negedge mclk_i) s = 1'b1;
    @(negedge mclk_i) s = 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic result(input result_word_t d, input channel_t c);
    result_data_i = d;
    result_channel_i = c;
    pulse(result_write_i);
  endtask
  task automatic rd(input logic [7:0] cmd, input int lead, input int n, input logic [31:0] exp);
    logic [31:0] rx;
    host.xfer(cmd, lead, n, rx);
    chk(rx, exp);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk(converter_status_o, 8'h80);
    chk(dout_o, 1'b1);
    chk(dout_oe_n_o, 1'b1);
    rd(8'h40, 0, 8, 8'h80);
    rd(8'h08, 0, 8, 8'hff);
    rd(8'h48, 2, 8, 8'hff);
    $display("Test reset done");
    parity_check_enable_i = 1'b1;
    append_status_to_data_i = 1'b1;
    result(24'h000007, 4'ha);
    chk(converter_status_o, 8'h1a);
    chk(dout_o, 1'b0);
    rd(8'h40, 3, 8, 8'h1a);
    rd(8'h58, 0, 32, 32'h0000071a);
    repeat (6) @(negedge mclk_i);
    chk(converter_status_o, 8'h9a);
    $display("Test read done");
    result(24'hffffff, 4'h3);
    chk(converter_status_o, 8'h43);
    result(24'h000000, 4'h3);
    chk(converter_status_o, 8'h43);
    parity_check_enable_i = 1'b0;
    result(24'h000003, 4'h5);
    chk(converter_status_o, 8'h05);
    $display("Test clamp done");
    pulse(pre_update_i);
    chk(converter_status_o, 8'h85);
    result(24'h000003, 4'h5);
    pulse(power_down_entry_i);
    chk(converter_status_o, 8'h85);
    result(24'h000003, 4'h5);
    pulse(idle_entry_i);
    chk(converter_status_o, 8'h85);
    result(24'h000003, 4'h5);
    sync_n_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    result(24'h000003, 4'h5);
    chk(converter_status_o, 8'h85);
    sync_n_i = 1'b1;
    $display("Test events done");
    cal_ref_invalid_i = 1'b1;
    pulse(cal_done_i);
    chk(converter_status_o[6], 1'b1);
    cal_ref_invalid_i = 1'b0;
    system_cal_i = 1'b1;
    cal_input_out_of_range_i = 1'b1;
    pulse(cal_done_i);
    chk(converter_status_o[6], 1'b1);
    cal_input_out_of_range_i = 1'b0;
    pulse(cal_done_i);
    chk(converter_status_o[6], 1'b0);
    $display("Test calibration done");
    reference_detect_enable_i = 1'b1;
    reference_below_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk(missing_reference_flag_o, 1'b1);
    result(24'h000001, 4'h2);
    chk(stored_result_o, 24'hffffff);
    rd(8'h40, 0, 8, 8'h62);
    reference_below_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk(missing_reference_flag_o, 1'b0);
    reference_below_i = 1'b1;
    reference_detect_enable_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk(missing_reference_flag_o, 1'b0);
    $display("Test reference done");
    append_status_to_data_i = 1'b0;
    rd(8'h58, 0, 24, 32'h00ffffff);
    repeat (6) @(negedge mclk_i);
    chk(converter_status_o, 8'hc2);
    @(negedge mclk_i) reset_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk(converter_status_o, 8'h80);
    chk(stored_result_o, 24'h000000);
    rd(8'h40, 0, 8, 8'h80);
    $display("Test second reset done");
    results();
  end
endmodule
`default_nettype wire
